// File: inc/ampctl_map.svh
// ampctl_map.svh: addresses, subaddress map, field positions and reset values
// assumes: included by bare name from the package and design files
`ifndef AMPCTL_MAP_SVH
`define AMPCTL_MAP_SVH

// fixed 7-bit bus address, 0011011 (0x36 as write byte)
`define AMPCTL_DEV_ADDR     7'h1B

// subaddress map
`define AMPCTL_STATUS_SUB   8'h00
`define AMPCTL_GEN_FIRST    8'h01
`define AMPCTL_GEN_LAST     8'h0F
`define AMPCTL_MIX_FIRST    8'h30
`define AMPCTL_MIX_LAST     8'h37
`define AMPCTL_BQ_FIRST     8'h40
`define AMPCTL_BQ_LAST      8'h47

// bytes per data set of each register kind
`define AMPCTL_BYTES_BYTE   5'h01
`define AMPCTL_BYTES_MIX    5'h04
`define AMPCTL_BYTES_BQ     5'h14
`define AMPCTL_BQ_WORDS     5

// coefficient width, stored right aligned in a 32-bit word
`define AMPCTL_COEF_W       26

// status byte field and reset values
`define AMPCTL_STAT_DISC    0
`define AMPCTL_GEN_RESET    8'h00
`define AMPCTL_COEF_RESET   26'h0000000

`endif

// File: inc/ampctl_pkg.sv
// ampctl_pkg: types and shared decode for the amplifier control slave
// assumes: ampctl_map.svh on the include path
`include "ampctl_map.svh"
`default_nettype none

package ampctl_pkg;

  // protocol engine states
  typedef enum logic [2:0] {
    AMPCTL_ST_IDLE   = 3'b000,
    AMPCTL_ST_ADDR   = 3'b001,
    AMPCTL_ST_AACK   = 3'b010,
    AMPCTL_ST_RX     = 3'b011,
    AMPCTL_ST_RXACK  = 3'b100,
    AMPCTL_ST_TX     = 3'b101,
    AMPCTL_ST_TXACK  = 3'b110,
    AMPCTL_ST_IGNORE = 3'b111
  } ampctl_state_t;

  // register kind behind a subaddress
  typedef enum logic [2:0] {
    AMPCTL_K_STAT = 3'b000,
    AMPCTL_K_GEN  = 3'b001,
    AMPCTL_K_MIX  = 3'b010,
    AMPCTL_K_BQ   = 3'b011,
    AMPCTL_K_NONE = 3'b100
  } ampctl_kind_t;

  // one complete data set to commit, right aligned, first byte highest
  typedef struct packed {
    logic         valid;
    logic [7:0]   sub;
    logic [159:0] data;
  } ampctl_wr_t;

  // the two bus pins as sampled
  typedef struct packed {
    logic scl;
    logic sda;
  } ampctl_pins_t;

  // kind of register at a subaddress
  function automatic ampctl_kind_t ampctl_kind(input logic [7:0] sub);
    if (sub == `AMPCTL_STATUS_SUB) return AMPCTL_K_STAT;
    if (sub >= `AMPCTL_GEN_FIRST && sub <= `AMPCTL_GEN_LAST) return AMPCTL_K_GEN;
    if (sub >= `AMPCTL_MIX_FIRST && sub <= `AMPCTL_MIX_LAST) return AMPCTL_K_MIX;
    if (sub >= `AMPCTL_BQ_FIRST && sub <= `AMPCTL_BQ_LAST) return AMPCTL_K_BQ;
    return AMPCTL_K_NONE;
  endfunction

  // bytes in one data set at a subaddress
  function automatic logic [4:0] ampctl_unit(input logic [7:0] sub);
    case (ampctl_kind(sub))
      AMPCTL_K_MIX: return `AMPCTL_BYTES_MIX;
      AMPCTL_K_BQ:  return `AMPCTL_BYTES_BQ;
      default:      return `AMPCTL_BYTES_BYTE;
    endcase
  endfunction

  // byte idx of a right-aligned set of unit bytes, most significant first
  function automatic logic [7:0] ampctl_pick(input logic [159:0] d,
                                             input logic [4:0]   unit,
                                             input logic [4:0]   idx);
    logic [4:0]   sh;
    logic [159:0] t;
    sh = unit - idx - 5'h01;
    t  = d >> {sh, 3'h0};
    return t[7:0];
  endfunction

endpackage

`default_nettype wire

// File: logic/ampctl_sync.sv
// ampctl_sync: two-flop synchroniser for the bus pins
// assumes: pins are asynchronous to clk; only q is read downstream
`include "ampctl_map.svh"
`default_nettype none

module ampctl_sync
  import ampctl_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // pins in, synchronised out
  input  wire ampctl_pins_t d,
  output var  ampctl_pins_t q
);

  ampctl_pins_t meta_ff;   // first stage, read only by the second

  // two stages; idle bus level is high on both lines
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_ff <= '{scl: 1'b1, sda: 1'b1};
      q       <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule

`default_nettype wire

// File: logic/ampctl_store.sv
// ampctl_store: general control bytes and coefficient arrays
// assumes: wr is a one-cycle commit of a complete data set from the slave
`include "ampctl_map.svh"
`default_nettype none

module ampctl_store
  import ampctl_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // commit from the protocol engine
  input  wire ampctl_wr_t   wr,
  // read side of the protocol engine
  input  wire logic [7:0]   rd_sub,
  input  wire logic [7:0]   status,
  output logic [159:0]      rd_data,
  // audio processor side
  output logic [119:0]      ctrl_regs,
  input  wire logic [5:0]   coef_rd_addr,
  output logic [25:0]       coef_rd_data
);

  logic [7:0]  gen_mem [1:15];  // general control bytes
  logic [25:0] mix_mem [0:7];   // mixer coefficients
  logic [25:0] bq_mem  [0:39];  // five words per filter section
  logic [5:0]  wr_base;         // first word of the written section
  logic [5:0]  rd_base;         // first word of the read section

  assign wr_base = {3'h0, wr.sub[2:0]} * 6'h05;
  assign rd_base = {3'h0, rd_sub[2:0]} * 6'h05;

  // commit a whole set at once, nothing partial ever lands here
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 1; i < 16; i++) gen_mem[i] <= `AMPCTL_GEN_RESET;
      for (int i = 0; i < 8; i++) mix_mem[i] <= `AMPCTL_COEF_RESET;
      for (int i = 0; i < 40; i++) bq_mem[i] <= `AMPCTL_COEF_RESET;
    end else if (wr.valid) begin
      case (ampctl_kind(wr.sub))
        AMPCTL_K_GEN: gen_mem[wr.sub[3:0]] <= wr.data[7:0];
        AMPCTL_K_MIX: mix_mem[wr.sub[2:0]] <= wr.data[25:0];
        AMPCTL_K_BQ: begin
          for (int w = 0; w < `AMPCTL_BQ_WORDS; w++) begin
            bq_mem[wr_base + 6'(w)] <= wr.data[153 - 32 * w -: 26];
          end
        end
        default: ;  // status and unmapped: written bytes are dropped
      endcase
    end
  end

  // read image, unused high bits of each word are zero
  always_comb begin
    rd_data = '0;
    case (ampctl_kind(rd_sub))
      AMPCTL_K_STAT: rd_data[7:0] = status;
      AMPCTL_K_GEN:  rd_data[7:0] = gen_mem[rd_sub[3:0]];
      AMPCTL_K_MIX:  rd_data[31:0] = {6'h00, mix_mem[rd_sub[2:0]]};
      AMPCTL_K_BQ: begin
        for (int w = 0; w < `AMPCTL_BQ_WORDS; w++) begin
          rd_data[159 - 32 * w -: 32] = {6'h00, bq_mem[rd_base + 6'(w)]};
        end
      end
      default: rd_data = '0;
    endcase
  end

  // general bytes flattened, subaddress 1 in the low byte
  always_comb begin
    for (int i = 1; i < 16; i++) ctrl_regs[8 * (i - 1) +: 8] = gen_mem[i];
  end

  // coefficient port: 0..7 mixer, 8..47 filter words, others zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      coef_rd_data <= `AMPCTL_COEF_RESET;
    end else if (coef_rd_addr < 6'h08) begin
      coef_rd_data <= mix_mem[coef_rd_addr[2:0]];
    end else if (coef_rd_addr < 6'h30) begin
      coef_rd_data <= bq_mem[coef_rd_addr - 6'h08];
    end else begin
      coef_rd_data <= `AMPCTL_COEF_RESET;
    end
  end

  AST_MIX_HIGH_ZERO: assert property (@(posedge clk) disable iff (reset)
    (ampctl_kind(rd_sub) == AMPCTL_K_MIX) |-> (rd_data[159:26] == '0))
    else $error("mixer read image has nonzero unused bits");

endmodule

`default_nettype wire

// File: logic/ampctl_i2c_slave.sv
// ampctl_i2c_slave: two-wire control slave of the amplifier
// assumes: scl and sda arrive unsynchronised; sda is open drain outside
//
// What this block does
// - works at 100 kHz and 400 kHz rates
// - never holds clock low; single master only
// - bytes are eight bits, most significant first
// - receiver acknowledges each byte next clock period
// - data changes while clock low, sampled high
// - acknowledge holds data low whole clock period
// - answers only to bus address 0011011
// - any number of bytes between start, stop
// - coefficient registers accessed only in whole words
// - read streams bytes while master keeps acknowledging
// - unused bits of narrow registers read zero
// - filter write needs five words, else dropped
// - mixer write commits after exactly one word
// - sequential sets go to consecutive subaddresses
// - only trailing partial set is dropped
// - write: address, subaddress, data, then stop
// - read: subaddress write, repeated start, read
// - keeps working without audio master clock
// - large writes may split only at whole-set boundaries
`include "ampctl_map.svh"
`default_nettype none

module ampctl_i2c_slave
  import ampctl_pkg::*;
(
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // bus pins
  input  wire logic         scl_i,
  input  wire logic         sda_i,
  output logic              sda_o,
  output logic              sda_oe,
  // audio processor side
  output logic [119:0]      ctrl_regs,
  input  wire logic [5:0]   coef_rd_addr,
  output logic [25:0]       coef_rd_data
);

  ampctl_pins_t  pin_s;        // synchronised pins
  ampctl_pins_t  pin_d_ff;     // one cycle older copy
  logic          start_ev;     // start or repeated start seen
  logic          stop_ev;      // stop seen
  logic          scl_rise;     // rising clock edge
  logic          scl_fall;     // falling clock edge
  ampctl_state_t state_ff;     // engine state
  logic [3:0]    bit_cnt_ff;   // bits moved in the current byte
  logic [7:0]    shift_ff;     // receive shifter
  logic [7:0]    tx_ff;        // transmit shifter
  logic          rw_ff;        // direction bit of this transfer
  logic          have_sub_ff;  // subaddress byte taken in this write
  logic [7:0]    sub_ff;       // current subaddress
  logic [4:0]    byte_idx_ff;  // byte within the current data set
  logic [159:0]  stage_ff;     // bytes of the set being received
  logic          mack_ff;      // master acknowledged our byte
  logic          disc_ff;      // last incomplete set was dropped
  logic          sda_oe_ff;    // pulling data low
  ampctl_wr_t    wr_ff;        // commit pulse to the store
  logic [159:0]  rd_data;      // read image at the current subaddress
  logic [4:0]    unit;         // bytes in a set at the current subaddress
  logic          byte_in;      // eight bits received, decided at this fall
  logic          set_done;     // received byte completes a data set
  logic [4:0]    nxt_byte_idx; // byte index after the received byte
  logic [7:0]    tx_next;      // byte to send at the read pointer
  ampctl_pins_t  pin_raw;      // pins as they arrive

  // pins pass two flops; sampling at 50 MHz covers both rates
  assign pin_raw = '{scl: scl_i, sda: sda_i};
  ampctl_sync u_sync (
    .clk   (ref_clk),
    .reset (reset),
    .d     (pin_raw),
    .q     (pin_s)
  );

  // older copy for edge and condition detection
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pin_d_ff <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      pin_d_ff <= pin_s;
    end
  end

  // data edges while clock high frame a transfer
  assign start_ev = pin_s.scl && pin_d_ff.scl && pin_d_ff.sda && !pin_s.sda;
  assign stop_ev  = pin_s.scl && pin_d_ff.scl && !pin_d_ff.sda && pin_s.sda;
  assign scl_rise = pin_s.scl && !pin_d_ff.scl;
  assign scl_fall = !pin_s.scl && pin_d_ff.scl;

  // set bookkeeping for the received byte
  assign unit         = ampctl_unit(sub_ff);
  assign byte_in      = scl_fall && (bit_cnt_ff == 4'h8);
  assign nxt_byte_idx = byte_idx_ff + 5'h01;
  assign set_done     = (nxt_byte_idx == unit);
  assign tx_next      = ampctl_pick(rd_data, unit, byte_idx_ff);

  // only pulls low, never drives high; clock is never touched
  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_ff;

  // sample data on rising clock while receiving, msb first
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      shift_ff <= 8'h00;
    end else if (scl_rise && (state_ff == AMPCTL_ST_ADDR || state_ff == AMPCTL_ST_RX)) begin
      shift_ff <= {shift_ff[6:0], pin_s.sda};
    end
  end

  // master acknowledge after each byte we send
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      mack_ff <= 1'b0;
    end else if (scl_rise && state_ff == AMPCTL_ST_TXACK) begin
      mack_ff <= !pin_s.sda;
    end
  end

  // protocol engine
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_ff   <= AMPCTL_ST_IDLE;
      bit_cnt_ff <= 4'h0;
      rw_ff      <= 1'b0;
      sda_oe_ff  <= 1'b0;
      tx_ff      <= 8'h00;
    end else if (start_ev) begin
      // any start restarts counting
      state_ff   <= AMPCTL_ST_ADDR;
      bit_cnt_ff <= 4'h0;
      sda_oe_ff  <= 1'b0;
    end else if (stop_ev) begin
      state_ff   <= AMPCTL_ST_IDLE;
      bit_cnt_ff <= 4'h0;
      sda_oe_ff  <= 1'b0;
    end else if (scl_rise && (state_ff == AMPCTL_ST_ADDR || state_ff == AMPCTL_ST_RX)) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end else if (scl_fall) begin
      // all pin changes happen just after clock falls
      case (state_ff)
        AMPCTL_ST_ADDR: begin
          if (bit_cnt_ff == 4'h8) begin
            bit_cnt_ff <= 4'h0;
            if (shift_ff[7:1] == `AMPCTL_DEV_ADDR) begin
              state_ff  <= AMPCTL_ST_AACK;
              sda_oe_ff <= 1'b1;
              rw_ff     <= shift_ff[0];
            end else begin
              state_ff  <= AMPCTL_ST_IGNORE;  // stay off the bus
            end
          end
        end
        AMPCTL_ST_AACK: begin
          if (rw_ff) begin
            // first read byte from the held subaddress
            state_ff   <= AMPCTL_ST_TX;
            tx_ff      <= tx_next;
            sda_oe_ff  <= !tx_next[7];
            bit_cnt_ff <= 4'h1;
          end else begin
            state_ff  <= AMPCTL_ST_RX;
            sda_oe_ff <= 1'b0;
          end
        end
        AMPCTL_ST_RX: begin
          if (bit_cnt_ff == 4'h8) begin
            state_ff   <= AMPCTL_ST_RXACK;  // ack every byte
            sda_oe_ff  <= 1'b1;
            bit_cnt_ff <= 4'h0;
          end
        end
        AMPCTL_ST_RXACK: begin
          state_ff  <= AMPCTL_ST_RX;
          sda_oe_ff <= 1'b0;
        end
        AMPCTL_ST_TX: begin
          if (bit_cnt_ff == 4'h8) begin
            state_ff  <= AMPCTL_ST_TXACK;  // release for master answer
            sda_oe_ff <= 1'b0;
          end else begin
            tx_ff      <= {tx_ff[6:0], 1'b0};  // msb first
            sda_oe_ff  <= !tx_ff[6];
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
        end
        AMPCTL_ST_TXACK: begin
          if (mack_ff) begin
            // keep streaming while acknowledged
            state_ff   <= AMPCTL_ST_TX;
            tx_ff      <= tx_next;
            sda_oe_ff  <= !tx_next[7];
            bit_cnt_ff <= 4'h1;
          end else begin
            state_ff  <= AMPCTL_ST_IGNORE;  // no-ack ends the read
            sda_oe_ff <= 1'b0;
          end
        end
        default: sda_oe_ff <= 1'b0;  // idle and ignore stay released
      endcase
    end
  end

  // subaddress, set index and staging; a start or stop drops any partial set
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      have_sub_ff <= 1'b0;
      sub_ff      <= 8'h00;
      byte_idx_ff <= 5'h00;
      stage_ff    <= '0;
    end else if (start_ev || stop_ev) begin
      have_sub_ff <= 1'b0;  // next write opens with a subaddress
      byte_idx_ff <= 5'h00;
      stage_ff    <= '0;
    end else if (byte_in && state_ff == AMPCTL_ST_RX) begin
      if (!have_sub_ff) begin
        have_sub_ff <= 1'b1;
        sub_ff      <= shift_ff;
        byte_idx_ff <= 5'h00;
      end else if (set_done) begin
        sub_ff      <= sub_ff + 8'h01;  // next set, next subaddress
        byte_idx_ff <= 5'h00;
        stage_ff    <= '0;
      end else begin
        byte_idx_ff <= nxt_byte_idx;
        stage_ff    <= {stage_ff[151:0], shift_ff};
      end
    end else if (scl_fall && state_ff == AMPCTL_ST_TX && bit_cnt_ff == 4'h8) begin
      // read pointer moves per byte, then per set
      if (set_done) begin
        sub_ff      <= sub_ff + 8'h01;
        byte_idx_ff <= 5'h00;
      end else begin
        byte_idx_ff <= nxt_byte_idx;
      end
    end
  end

  // commit only whole sets: one word for mixer, five for filters
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_ff <= '0;
    end else if (byte_in && state_ff == AMPCTL_ST_RX && have_sub_ff && set_done) begin
      wr_ff.valid <= 1'b1;
      wr_ff.sub   <= sub_ff;
      wr_ff.data  <= {stage_ff[151:0], shift_ff};
    end else begin
      wr_ff.valid <= 1'b0;
    end
  end

  // dropped-set flag for status; a commit clears it
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      disc_ff <= 1'b0;
    end else if ((start_ev || stop_ev) && byte_idx_ff != 5'h00 && !rw_ff) begin
      disc_ff <= 1'b1;
    end else if (wr_ff.valid) begin
      disc_ff <= 1'b0;
    end
  end

  // register storage, all on ref_clk so no audio clock is needed
  ampctl_store u_store (
    .clk          (ref_clk),
    .reset        (reset),
    .wr           (wr_ff),
    .rd_sub       (sub_ff),
    .status       ({7'h00, disc_ff}),
    .rd_data      (rd_data),
    .ctrl_regs    (ctrl_regs),
    .coef_rd_addr (coef_rd_addr),
    .coef_rd_data (coef_rd_data)
  );

  AST_FOREIGN_SILENT: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == AMPCTL_ST_IGNORE) |-> !sda_oe_ff)
    else $error("data pulled low while ignoring the bus");

  AST_ADDR_ACK: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == AMPCTL_ST_ADDR && byte_in && shift_ff[7:1] == `AMPCTL_DEV_ADDR
     && !start_ev && !stop_ev) |=> (state_ff == AMPCTL_ST_AACK && sda_oe_ff))
    else $error("own address not acknowledged");

  AST_ACK_HELD: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == AMPCTL_ST_RXACK || state_ff == AMPCTL_ST_AACK) |-> sda_oe_ff)
    else $error("acknowledge released early");

  AST_PIN_CHANGE_LOW: assert property (@(posedge ref_clk) disable iff (reset)
    $changed(sda_oe_ff) |-> ($past(scl_fall) || $past(start_ev) || $past(stop_ev)))
    else $error("data pin changed outside clock low");

  AST_MSB_FIRST: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == AMPCTL_ST_TX && scl_fall && bit_cnt_ff < 4'h8 && !start_ev && !stop_ev)
    |=> (sda_oe_ff == !$past(tx_ff[6])))
    else $error("transmit bit order wrong");

  AST_DROP_PARTIAL: assert property (@(posedge ref_clk) disable iff (reset)
    (start_ev || stop_ev) |=> (byte_idx_ff == 5'h00 && !wr_ff.valid))
    else $error("partial set survived a start or stop");

  AST_MIX_ONE_WORD: assert property (@(posedge ref_clk) disable iff (reset)
    (byte_in && state_ff == AMPCTL_ST_RX && have_sub_ff && !start_ev && !stop_ev
     && ampctl_kind(sub_ff) == AMPCTL_K_MIX && byte_idx_ff == 5'h03)
    |=> (wr_ff.valid && wr_ff.sub == $past(sub_ff)))
    else $error("mixer word not committed after four bytes");

  AST_SEQ_NEXT: assert property (@(posedge ref_clk) disable iff (reset)
    (wr_ff.valid && !$past(start_ev) && !$past(stop_ev)) |-> (sub_ff == wr_ff.sub + 8'h01))
    else $error("subaddress did not advance after a set");

  AST_NACK_ENDS: assert property (@(posedge ref_clk) disable iff (reset)
    (state_ff == AMPCTL_ST_TXACK && scl_fall && !mack_ff && !start_ev && !stop_ev)
    |=> (state_ff == AMPCTL_ST_IGNORE) ##1 !sda_oe_ff)
    else $error("read did not stop after no-acknowledge");

  AST_START_RESTART: assert property (@(posedge ref_clk) disable iff (reset)
    start_ev |=> (state_ff == AMPCTL_ST_ADDR && bit_cnt_ff == 4'h0 && !sda_oe_ff))
    else $error("start did not restart the engine");

endmodule

`default_nettype wire

// File: verif/ampctl_master_model.sv
// ampctl_master_model: two-wire bus master standing in for the controller
// assumes: sda is the wired-AND bus level with a pull-up, fed back in
`default_nettype none

module ampctl_master_model (
  // bus pins
  output var  logic scl,
  output var  logic sda_m,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  logic lclk = 1'b0; // link clock, 30 ns, free of ref_clk phase

  // link clock generator
  always #15 lclk = ~lclk;

  // bus idles high, clock stands still between frames
  initial begin
    scl   = 1'b1;
    sda_m = 1'b1;
  end

  // quarter bit, 630 ns: a bit period just under 400 kHz
  task automatic q();
    repeat (21) @(posedge lclk);
  endtask

  // start or repeated start: data falls while clock high
  task automatic start();
    sda_m = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_m = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask

  // stop: data rises while clock high
  task automatic stop();
    sda_m = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_m = 1'b1;
    q();
  endtask

  // one bit: change while low, sample while high
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    q();
    scl = 1'b1;
    q();
    r = sda;
    q();
    scl = 1'b0;
    q();
  endtask

  // byte msb first, then the ack bit period
  task automatic xfer(input logic [7:0] tx, input logic ackm,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(ackm, ack);
  endtask
endmodule

`default_nettype wire

// File: verif/tb.sv
// tb: self-checking bench for the amplifier control slave
// assumes: design package compiled first; master model drives the pins
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic         ref_clk      = 1'b0; // system clock
  logic         reset        = 1'b1; // async reset
  logic [5:0]   coef_rd_addr = 6'h00; // coefficient select
  wire  logic   scl;                  // bus clock from master
  wire  logic   sda_m;                // master data drive
  logic         sda_o;                // slave data value
  logic         sda_oe;               // slave pulls data low
  logic [119:0] ctrl_regs;            // general bytes
  logic [25:0]  coef_rd_data;         // selected coefficient
  int           n_mismatch   = 0;     // mismatch count
  int           num_checks   = 0;     // comparison count
  int           cyc          = 0;     // timeout counter
  wire  logic   sda = sda_m & (sda_oe ? sda_o : 1'b1); // wired-AND, pull-up

  always #10 ref_clk = ~ref_clk;

  ampctl_i2c_slave u_ampctl_i2c_slave (.ref_clk(ref_clk), .reset(reset),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .ctrl_regs(ctrl_regs), .coef_rd_addr(coef_rd_addr), .coef_rd_data(coef_rd_data));

  ampctl_master_model m (.scl(scl), .sda_m(sda_m), .sda(sda));

  // verdict and end of run
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_mismatch++;
      conclude();
    end
  end

  // ack bit compare, 0 means acknowledged
  task automatic chk_ack(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: ack %b expected %b", $time, got, exp);
    end
  endtask

  // data value compare
  task automatic chk_val(input logic [25:0] got, input logic [25:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // write one byte, check the slave's answer
  task automatic send(input logic [7:0] b, input logic exp_ack);
    logic [7:0] r;
    logic       a;
    m.xfer(b, 1'b1, r, a);
    chk_ack(a, exp_ack);
  endtask

  // read one byte, master acks unless last
  task automatic recv(input logic [7:0] exp, input logic last);
    logic [7:0] r;
    logic       a;
    m.xfer(8'hFF, last, r, a);
    chk_val({18'h0, r}, {18'h0, exp});
  endtask

  // coefficient word readback
  task automatic coef(input logic [5:0] a, input logic [25:0] e);
    @(posedge ref_clk) coef_rd_addr <= a;
    repeat (3) @(negedge ref_clk);
    chk_val(coef_rd_data, e);
  endtask

  // mixer word, top six bits ignored
  task automatic t_mixer();
    m.start();
    send(8'h36, 1'b0);
    send(8'h30, 1'b0);
    send(8'hFF, 1'b0);
    send(8'h02, 1'b0);
    send(8'h03, 1'b0);
    send(8'h04, 1'b0);
    m.stop();
    coef(6'h00, 26'h3020304);
  endtask

  // foreign address left unanswered
  task automatic t_foreign();
    m.start();
    send(8'h38, 1'b1);
    send(8'h30, 1'b1);
    m.stop();
  endtask

  // general bytes written in sequence, then read back in sequence
  task automatic t_gen();
    m.start();
    send(8'h36, 1'b0);
    send(8'h01, 1'b0);
    send(8'hA5, 1'b0);
    send(8'h5A, 1'b0);
    m.stop();
    chk_val({10'h0, ctrl_regs[15:0]}, 26'h0005AA5);
    m.start();
    send(8'h36, 1'b0);
    send(8'h01, 1'b0);
    m.start();
    send(8'h37, 1'b0);
    recv(8'hA5, 1'b0);
    recv(8'h5A, 1'b1);
    m.stop();
  endtask

  // mixer readback with repeated start, unused bits zero
  task automatic t_read();
    m.start();
    send(8'h36, 1'b0);
    send(8'h30, 1'b0);
    m.start();
    send(8'h37, 1'b0);
    recv(8'h03, 1'b0);
    recv(8'h02, 1'b0);
    recv(8'h03, 1'b0);
    recv(8'h04, 1'b1);
    m.stop();
  endtask

  // one filter set plus a trailing partial set, then status
  task automatic t_bq();
    m.start();
    send(8'h36, 1'b0);
    send(8'h40, 1'b0);
    for (int i = 1; i <= 24; i++) begin
      send(8'(i), 1'b0);
    end
    m.stop();
    coef(6'h08, 26'h1020304);
    coef(6'h0C, 26'h1121314);
    coef(6'h0D, 26'h0000000);
    m.start();
    send(8'h36, 1'b0);
    send(8'h00, 1'b0);
    m.start();
    send(8'h37, 1'b0);
    recv(8'h01, 1'b1);
    m.stop();
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (10) @(posedge ref_clk);
    t_mixer();
    t_foreign();
    t_gen();
    t_read();
    t_bq();
    conclude();
  end
endmodule

`default_nettype wire
